/* core/acr_pkg.sv */
// Constants, field positions and types shared by the converter control register block.
package acr_pkg;
  // Control register layout and reset value.
  localparam int          CTRL_W        = 16;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_RSVD_MSK = 16'hE000;
  localparam int          RDY_DEL_BIT   = 12;
  localparam int          CONT_RD_BIT   = 11;
  localparam int          APPEND_BIT    = 10;
  localparam int          CS_FRAME_BIT  = 9;
  localparam int          REF_EN_BIT    = 8;
  localparam int          PWR_MSB       = 7;
  localparam int          PWR_LSB       = 6;
  localparam int          MODE_MSB      = 5;
  localparam int          MODE_LSB      = 2;
  localparam int          CLK_MSB       = 1;
  localparam int          CLK_LSB       = 0;

  // Command byte layout and register selects.
  localparam int          CMD_LEN      = 8;
  localparam int          CMD_READ_BIT = 6;
  localparam logic [5:0]  RS_STATUS    = 6'h00;
  localparam logic [5:0]  RS_CONTROL   = 6'h01;
  localparam logic [5:0]  RS_DATA      = 6'h02;
  localparam logic [7:0]  RD_DATA_CMD  = 8'h42;

  // Frame lengths in serial clocks.
  localparam logic [5:0]  LEN_STATUS   = 6'h08;
  localparam logic [5:0]  LEN_CTRL     = 6'h10;
  localparam logic [5:0]  LEN_DATA     = 6'h18;
  localparam logic [5:0]  LEN_DATA_ST  = 6'h20;
  localparam logic [5:0]  LEN_CMD_LAST = 6'h07;

  // Serial reset on the next one after this many ones in a row.
  localparam logic [6:0]  RESET_ONES_LAST = 7'h3F;

  // Ready release delay, least times rounded up to whole clocks.
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          DEL_SHORT_NS   = 10;
  localparam int          DEL_LONG_NS    = 100;
  localparam int          DEL_SHORT_RAW  = (DEL_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DEL_LONG_RAW   = (DEL_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  DEL_SHORT_CYC  = 8'((DEL_SHORT_RAW < 1) ? 1 : DEL_SHORT_RAW);
  localparam logic [7:0]  DEL_LONG_CYC   = 8'((DEL_LONG_RAW < 1) ? 1 : DEL_LONG_RAW);

  // External clock divider for the fast external clock source.
  localparam int          EXT_DIV      = 4;
  localparam logic [1:0]  EXT_DIV_LAST = 2'(EXT_DIV - 1);

  // Operating mode codes with a dedicated decode.
  localparam logic [3:0]  MODE_CONT    = 4'h0;
  localparam logic [3:0]  MODE_SINGLE  = 4'h1;

  // Power mode selection as seen by the analog section.
  typedef enum logic [1:0] {
    PWR_LOW  = 2'b00,
    PWR_MID  = 2'b01,
    PWR_FULL = 2'b10
  } acr_pwr_t;

  // Clock source codes.
  typedef enum logic [1:0] {
    CLK_INT     = 2'b00,
    CLK_INT_OUT = 2'b01,
    CLK_EXT     = 2'b10,
    CLK_EXT_DIV = 2'b11
  } acr_clk_t;

  // Serial interface states.
  typedef enum logic [2:0] {
    ST_CMD   = 3'b000,
    ST_WRITE = 3'b001,
    ST_READ  = 3'b010,
    ST_HOLD  = 3'b011,
    ST_DELAY = 3'b100
  } acr_state_t;
endpackage

/* core/acr_sync.sv */
// Two flip-flop synchroniser for one asynchronous pin.
`timescale 1ns/10ps
module acr_sync (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous level in, synchronised level out.
  input  wire logic pinIn,
  output logic      syncOut
);
  logic meta_q;  // First stage, read only by the second stage.

  // The second stage absorbs any metastability of the first. Neither stage is
  // cleared by reset: both follow the pin through reset, so an idle-high pin
  // shows no false edge at release. Reset must therefore last two clocks or more.
  always_ff @(posedge clk) begin
    meta_q  <= pinIn;
    syncOut <= meta_q;
  end
endmodule

/* core/acr_control_register.sv */
// Converter control register with its serial read, write and framing logic.
// Operation
// - ready delay 10 ns, or 100 ns when set; both round up to one 100 ns clock here
// - continuous read shifts data after ready falls
// - read-data command while ready low ends it
// - input line monitored during continuous read
// - sixty-four ones on input reset the interface
// - append status after data when bit set
// - unframed: pin reverts to ready after delay
// - framed: last bit held until select rises
// - serial error diagnostics only when framed
// - reference enable drives reference output
// - power field: low, mid, full, full
// - bits five to two select operating mode
// - codes 00/01 internal oscillator, 01 drives pin
// - code 10 external direct, 11 divided by four
// - mode 0000 continuous, 0001 single conversion
// - register shifted most significant bit first
`timescale 1ns/10ps
module acr_control_register (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Serial pins from the host.
  input  wire logic             sclk,
  input  wire logic             din,
  input  wire logic             csN,
  output logic                  doutRdyN,
  // Converter core side.
  input  wire logic             convValid,
  input  wire logic [23:0]      convData,
  input  wire logic [6:0]       statusLow,
  // Clock sources.
  input  wire logic             oscTick,
  input  wire logic             extClk,
  // Configuration outputs.
  output logic                  referenceOutputPin,
  output acr_pkg::acr_pwr_t     powerMode,
  output logic [3:0]            opMode,
  output logic                  modeContinuous,
  output logic                  modeSingle,
  output logic                  clkOutEnable,
  output logic                  useExtClock,
  output logic                  modClkTick,
  // Diagnostic and reset pulses.
  output logic                  writeErr,
  output logic                  readErr,
  output logic                  serialClockCountError,
  output logic                  serialReset
);
  // Synchronised pins, in the order sclk, din, csN, extClk.
  logic [3:0] pinRaw;
  logic [3:0] pinSync;
  assign pinRaw = {extClk, csN, din, sclk};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gSync
      acr_sync uSync (
        .clk     (clk),
        .rst     (rst),
        .pinIn   (pinRaw[gi]),
        .syncOut (pinSync[gi])
      );
    end
  endgenerate

  // Registered state.
  logic [15:0]         ctrl_q;       // Control register.
  acr_pkg::acr_state_t state_q;      // Serial phase.
  logic [5:0]          bitCnt_q;     // Rising edges counted in this phase.
  logic [5:0]          phaseLen_q;   // Length of the current data phase.
  logic [15:0]         rxShift_q;    // Bits collected from the input line.
  logic [31:0]         tx_q;         // Outgoing bits, most significant first.
  logic                doutBit_q;    // Bit now on the output pin.
  logic                rdyN_q;       // Low while unread data waits.
  logic                dataSel_q;    // Data register was the last read.
  logic [7:0]          delay_q;      // Ready release countdown.
  logic [6:0]          ones_q;       // Run of ones on the input line.
  logic [1:0]          div_q;        // External clock divider.
  logic [3:0]          edge_q;       // Previous synchronised levels.

  // Edge decode on the synchronised pins only.
  logic sclkRise, sclkFall, csRise, extRise, dinS, csActive;
  assign sclkRise = pinSync[0] & ~edge_q[0];
  assign sclkFall = ~pinSync[0] & edge_q[0];
  assign dinS     = pinSync[1];
  assign csRise   = pinSync[2] & ~edge_q[2];
  assign csActive = ~pinSync[2];
  assign extRise  = pinSync[3] & ~edge_q[3];

  // Control fields.
  logic csFrame, appendSt, contRead, longDel;
  logic [1:0] clkSel;
  assign csFrame  = ctrl_q[acr_pkg::CS_FRAME_BIT];
  assign appendSt = ctrl_q[acr_pkg::APPEND_BIT];
  assign contRead = ctrl_q[acr_pkg::CONT_RD_BIT];
  assign longDel  = ctrl_q[acr_pkg::RDY_DEL_BIT];
  assign clkSel   = ctrl_q[acr_pkg::CLK_MSB:acr_pkg::CLK_LSB];

  // Status byte carries the ready bit on top.
  logic [7:0] statusByte;
  assign statusByte = {rdyN_q, statusLow};

  // Frame length of a data read, with or without status appended.
  function automatic logic [5:0] dataLen(input logic app);
    dataLen = app ? acr_pkg::LEN_DATA_ST : acr_pkg::LEN_DATA;
  endfunction

  // Data read image, status after the data when appended.
  function automatic logic [31:0] dataImg(input logic app, input logic [23:0] d,
                                          input logic [7:0] st);
    dataImg = app ? {d, st} : {d, 8'h00};
  endfunction

  // Decode of a completed command byte.
  logic       rise, cmdDone, phaseDone, contActive, contLoad;
  logic [7:0] rxByte;
  logic [5:0] rs;
  logic       isRead;
  assign rise       = sclkRise & csActive;
  assign rxByte     = {rxShift_q[6:0], dinS};
  assign rs         = rxByte[5:0];
  assign isRead     = rxByte[acr_pkg::CMD_READ_BIT];
  assign cmdDone    = (state_q == acr_pkg::ST_CMD) & rise
                    & (bitCnt_q == acr_pkg::LEN_CMD_LAST);
  assign phaseDone  = rise & (bitCnt_q == phaseLen_q - 6'h01);
  assign contActive = contRead & dataSel_q;
  // In continuous read, a new result starts a read without any command.
  assign contLoad   = contActive & ~rdyN_q & csActive
                    & (state_q == acr_pkg::ST_CMD) & (bitCnt_q == 6'h00);
  // The first byte of a continuous read is checked for the exit command.
  logic exitCmd;
  assign exitCmd    = contActive & (state_q == acr_pkg::ST_READ) & rise
                    & (bitCnt_q == acr_pkg::LEN_CMD_LAST)
                    & (rxByte == acr_pkg::RD_DATA_CMD);

  // Reset by a long run of ones on the input.
  logic onesReset;
  assign onesReset = rise & dinS & (ones_q == acr_pkg::RESET_ONES_LAST);

  // Diagnostics are gated by the framing bit.
  logic badWrite, badRead, cntBad;
  assign badWrite = csFrame & cmdDone & ~contLoad & ~isRead
                  & (rs != acr_pkg::RS_CONTROL);
  assign badRead  = csFrame & cmdDone & ~contLoad & isRead
                  & (rs != acr_pkg::RS_CONTROL) & (rs != acr_pkg::RS_DATA)
                  & (rs != acr_pkg::RS_STATUS);
  assign cntBad   = csFrame & csRise & ((bitCnt_q != 6'h00)
                  | (state_q == acr_pkg::ST_WRITE) | (state_q == acr_pkg::ST_READ));

  // Edge history and the ones run counter.
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_q <= pinSync;  // Idle pins must not look like edges after release.
      ones_q <= 7'h00;
    end else begin
      edge_q <= pinSync;
      if (rise) begin
        ones_q <= (dinS && !onesReset) ? ones_q + 7'h01 : 7'h00;
      end
    end
  end

  // Serial phase machine with the bit counter.
  always_ff @(posedge clk) begin
    if (rst || onesReset) begin
      state_q    <= acr_pkg::ST_CMD;
      bitCnt_q   <= 6'h00;
      phaseLen_q <= 6'h00;
      delay_q    <= 8'h00;
    end else if (!csActive) begin
      // A deselected interface always waits for a new command.
      state_q  <= acr_pkg::ST_CMD;
      bitCnt_q <= 6'h00;
    end else begin
      unique case (state_q)
        acr_pkg::ST_CMD: begin
          if (contLoad) begin
            state_q    <= acr_pkg::ST_READ;
            phaseLen_q <= dataLen(appendSt);
          end else if (cmdDone) begin
            bitCnt_q <= 6'h00;
            if (isRead && !badRead) begin
              state_q    <= acr_pkg::ST_READ;
              phaseLen_q <= (rs == acr_pkg::RS_DATA) ? dataLen(appendSt) :
                            (rs == acr_pkg::RS_CONTROL) ? acr_pkg::LEN_CTRL :
                            acr_pkg::LEN_STATUS;
            end else if (!isRead && rs == acr_pkg::RS_CONTROL) begin
              state_q    <= acr_pkg::ST_WRITE;
              phaseLen_q <= acr_pkg::LEN_CTRL;
            end
          end else if (rise) begin
            bitCnt_q <= bitCnt_q + 6'h01;
          end
        end
        acr_pkg::ST_WRITE: begin
          if (phaseDone) begin
            state_q  <= acr_pkg::ST_CMD;
            bitCnt_q <= 6'h00;
          end else if (rise) begin
            bitCnt_q <= bitCnt_q + 6'h01;
          end
        end
        acr_pkg::ST_READ: begin
          if (phaseDone) begin
            bitCnt_q <= 6'h00;
            // Framed reads hold the last bit; unframed ones release the pin.
            state_q  <= csFrame ? acr_pkg::ST_HOLD : acr_pkg::ST_DELAY;
            delay_q  <= longDel ? acr_pkg::DEL_LONG_CYC : acr_pkg::DEL_SHORT_CYC;
          end else if (rise) begin
            bitCnt_q <= bitCnt_q + 6'h01;
          end
        end
        acr_pkg::ST_HOLD: begin
          state_q <= acr_pkg::ST_HOLD;
        end
        acr_pkg::ST_DELAY: begin
          if (delay_q <= 8'h01) begin
            state_q <= acr_pkg::ST_CMD;
          end
          delay_q <= delay_q - 8'h01;
        end
        default: begin
          state_q <= acr_pkg::ST_CMD;
        end
      endcase
    end
  end

  // Input shifting and the control register write.
  always_ff @(posedge clk) begin
    if (rst || onesReset) begin
      rxShift_q <= 16'h0000;
      ctrl_q    <= acr_pkg::CTRL_RESET;
    end else begin
      if (rise) begin
        rxShift_q <= {rxShift_q[14:0], dinS};
      end
      if (exitCmd) begin
        ctrl_q[acr_pkg::CONT_RD_BIT] <= 1'b0;
      end else if (state_q == acr_pkg::ST_WRITE && phaseDone) begin
        // Reserved bits are kept at zero even if the host breaks the rule.
        ctrl_q <= {rxShift_q[14:0], dinS} & ~acr_pkg::CTRL_RSVD_MSK;
      end
    end
  end

  // Output shifting: each falling edge launches the next bit.
  logic readLoad;
  assign readLoad = contLoad | (cmdDone & isRead & ~badRead);
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_q      <= 32'h00000000;
      doutBit_q <= 1'b1;
      dataSel_q <= 1'b0;
    end else if (readLoad) begin
      // Data register reads may carry the status byte behind them.
      if (contLoad || rs == acr_pkg::RS_DATA) begin
        tx_q      <= dataImg(appendSt, convData, statusByte);
        dataSel_q <= 1'b1;
      end else begin
        tx_q      <= (rs == acr_pkg::RS_CONTROL) ? {ctrl_q, 16'h0000}
                                                 : {statusByte, 24'h000000};
        dataSel_q <= 1'b0;
      end
    end else if (sclkFall && csActive && state_q == acr_pkg::ST_READ) begin
      doutBit_q <= tx_q[31];
      tx_q      <= {tx_q[30:0], 1'b0};
    end
  end

  // Ready flag: a new result wins over a data read in the same cycle.
  logic dataTaken;
  assign dataTaken = readLoad & (contLoad | (rs == acr_pkg::RS_DATA));
  always_ff @(posedge clk) begin
    if (rst) begin
      rdyN_q <= 1'b1;
    end else if (convValid) begin
      rdyN_q <= 1'b0;
    end else if (dataTaken) begin
      rdyN_q <= 1'b1;
    end
  end

  // The pin shows data while a read owns it, otherwise the ready level.
  logic pinOwned;
  assign pinOwned = (state_q == acr_pkg::ST_READ) | (state_q == acr_pkg::ST_HOLD)
                  | (state_q == acr_pkg::ST_DELAY);
  assign doutRdyN = pinOwned ? doutBit_q : rdyN_q;

  // Modulator clock: internal ticks, external edges, or every fourth edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q      <= 2'h0;
      modClkTick <= 1'b0;
    end else begin
      unique case (clkSel)
        acr_pkg::CLK_INT, acr_pkg::CLK_INT_OUT: modClkTick <= oscTick;
        acr_pkg::CLK_EXT:                       modClkTick <= extRise;
        acr_pkg::CLK_EXT_DIV:                   modClkTick <= extRise
                                                   & (div_q == acr_pkg::EXT_DIV_LAST);
      endcase
      if (extRise) begin
        div_q <= div_q + 2'h1;
      end
    end
  end

  // Configuration decode, all driven from the control register.
  assign referenceOutputPin = ctrl_q[acr_pkg::REF_EN_BIT];
  assign powerMode = (ctrl_q[acr_pkg::PWR_MSB:acr_pkg::PWR_LSB] == 2'b00) ? acr_pkg::PWR_LOW :
                     (ctrl_q[acr_pkg::PWR_MSB:acr_pkg::PWR_LSB] == 2'b01) ? acr_pkg::PWR_MID :
                     acr_pkg::PWR_FULL;
  assign opMode         = ctrl_q[acr_pkg::MODE_MSB:acr_pkg::MODE_LSB];
  assign modeContinuous = (opMode == acr_pkg::MODE_CONT);
  assign modeSingle     = (opMode == acr_pkg::MODE_SINGLE);
  assign clkOutEnable   = (clkSel == acr_pkg::CLK_INT_OUT);
  assign useExtClock    = clkSel[1];

  // Diagnostic pulses, one clock each.
  always_ff @(posedge clk) begin
    if (rst) begin
      writeErr              <= 1'b0;
      readErr               <= 1'b0;
      serialClockCountError <= 1'b0;
      serialReset           <= 1'b0;
    end else begin
      writeErr              <= badWrite;
      readErr               <= badRead;
      serialClockCountError <= cntBad;
      serialReset           <= onesReset;
    end
  end
endmodule

/* bench/acr_checker.sv */
// Port checker for the converter control register, bound to its top module.
`timescale 1ns/10ps
module acr_checker (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              rst,
  // Serial pins.
  input wire logic              din,
  input wire logic              csN,
  input wire logic              doutRdyN,
  // Clock tick and configuration outputs.
  input wire logic              oscTick,
  input wire logic              referenceOutputPin,
  input wire acr_pkg::acr_pwr_t powerMode,
  input wire logic [3:0]        opMode,
  input wire logic              modeContinuous,
  input wire logic              modeSingle,
  input wire logic              clkOutEnable,
  input wire logic              useExtClock,
  input wire logic              modClkTick,
  // Pulses.
  input wire logic              serialClockCountError,
  input wire logic              serialReset
);
  logic [7:0] dinHigh; // Cycles with din high in a row, saturating.
  logic [3:0] csAge;   // Cycles with select high in a row, saturating.

  // Run lengths are counted because a 64-deep repetition would be too slow.
  always_ff @(posedge clk) begin
    if (rst || !din) dinHigh <= 8'h00;
    else if (dinHigh != 8'hFF) dinHigh <= dinHigh + 8'h01;
    if (rst || !csN) csAge <= 4'h0;
    else if (csAge != 4'hF) csAge <= csAge + 4'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_reset_cfg;
    $past(rst) |-> !referenceOutputPin && powerMode == acr_pkg::PWR_LOW && opMode == 4'h0
      && !useExtClock && doutRdyN;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("config not cleared by reset");
  property p_pwr_code;
    powerMode != 2'b11;
  endproperty
  a_pwr_code: assert property (p_pwr_code) else $error("power mode code 11 seen");
  property p_clk_out;
    clkOutEnable |-> !useExtClock;
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock driven out on external");
  property p_mode_cont;
    modeContinuous == (opMode == acr_pkg::MODE_CONT);
  endproperty
  a_mode_cont: assert property (p_mode_cont) else $error("continuous decode wrong");
  property p_mode_single;
    modeSingle == (opMode == acr_pkg::MODE_SINGLE);
  endproperty
  a_mode_single: assert property (p_mode_single) else $error("single decode wrong");
  property p_osc_tick;
    !$past(rst) && !useExtClock && !$past(useExtClock) |-> modClkTick == $past(oscTick);
  endproperty
  a_osc_tick: assert property (p_osc_tick) else $error("oscillator tick not passed");
  property p_ser_cause;
    serialReset |-> dinHigh >= 8'h40;
  endproperty
  a_ser_cause: assert property (p_ser_cause) else $error("serial reset without ones");
  property p_ser_effect;
    serialReset |-> ##[0:3] (opMode == 4'h0 && !referenceOutputPin
      && powerMode == acr_pkg::PWR_LOW);
  endproperty
  a_ser_effect: assert property (p_ser_effect) else $error("serial reset kept config");
  property p_cnt_err;
    serialClockCountError |-> csN && csAge <= 4'h8;
  endproperty
  a_cnt_err: assert property (p_cnt_err) else $error("count error without select rise");
  property p_cfg_quiet;
    !$past(rst) && $changed(opMode) |-> !$past(csN, 3);
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("mode changed outside a frame");
endmodule

bind acr_control_register acr_checker acr_checker_i (
  .clk(clk), .rst(rst), .din(din), .csN(csN), .doutRdyN(doutRdyN), .oscTick(oscTick),
  .referenceOutputPin(referenceOutputPin), .powerMode(powerMode), .opMode(opMode),
  .modeContinuous(modeContinuous), .modeSingle(modeSingle), .clkOutEnable(clkOutEnable),
  .useExtClock(useExtClock), .modClkTick(modClkTick),
  .serialClockCountError(serialClockCountError), .serialReset(serialReset));

/* bench/acr_host_model.sv */
// Host model acting as serial master of the converter control register.
`timescale 1ns/10ps
module acr_host_model (
  // Bench clock.
  input  wire logic   clk,
  // Serial pins toward the device.
  output logic        sclk,
  output logic        din,
  output logic        csN,
  input  wire logic   doutRdyN,
  // Result of the last frame.
  output logic        rxDone,
  output logic [31:0] rxData,
  output logic        rxHold
);
  // Idle: clock high, select high, data held low so no ones pile up.
  initial begin
    sclk = 1'b1;
    din = 1'b0;
    csN = 1'b1;
    rxDone = 1'b0;
    rxData = 32'h00000000;
    rxHold = 1'b1;
  end

  // Data changes at the falling edge; the reply is taken late in the low phase,
  // since the device sees the pins several clocks late through its synchronisers.
  task automatic bitx(input logic tx);
    @(posedge clk) sclk <= 1'b0;
    din <= tx;
    repeat (5) @(posedge clk);
    rxData <= {rxData[30:0], doutRdyN};
    sclk <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  // One framed transfer: optional command, then n bits most significant first.
  task automatic xfer(input logic [7:0] cmd, input logic useCmd, input int n,
                      input logic [63:0] tx);
    @(posedge clk) csN <= 1'b0;
    repeat (4) @(posedge clk);
    if (useCmd) begin
      for (int i = 7; i >= 0; i--) bitx(cmd[i]);
    end
    for (int i = n - 1; i >= 0; i--) bitx(tx[i]);
    @(posedge clk) din <= 1'b0;
    repeat (5) @(posedge clk);
    rxHold <= doutRdyN;
    rxDone <= 1'b1;
    @(posedge clk) rxDone <= 1'b0;
    csN <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

/* bench/testbench.sv */
// Self-checking bench for the converter control register.
`timescale 1ns/10ps
module testbench;
  logic              clk = 1'b0;           // Bench clock.
  logic              rst = 1'b1;           // Synchronous reset.
  logic              convValid = 1'b0;     // New result pulse.
  logic [23:0]       convData = 24'h000000;
  logic [6:0]        statusLow = 7'h00;
  logic              oscTick = 1'b0;
  logic              extClk = 1'b0;
  wire logic         sclk, din, csN, doutRdyN, rxDone, rxHold;
  wire logic [31:0]  rxData;
  acr_pkg::acr_pwr_t powerMode;
  logic [3:0]        opMode;
  logic              referenceOutputPin, modeContinuous, modeSingle, clkOutEnable;
  logic              useExtClock, modClkTick, writeErr, readErr, cntErr, serialReset;
  int                failures = 0;
  int                n_compared = 0;
  int                seed = 45;
  logic [31:0]       expQ[$];              // Expected frame replies.
  logic [31:0]       mskQ[$];              // Bits of each reply that are defined.
  logic [3:0]        seen = 4'h0;          // Sticky pulses.

  acr_control_register acr_control_register_i (.clk(clk), .rst(rst), .sclk(sclk),
    .din(din), .csN(csN), .doutRdyN(doutRdyN), .convValid(convValid),
    .convData(convData), .statusLow(statusLow), .oscTick(oscTick), .extClk(extClk),
    .referenceOutputPin(referenceOutputPin), .powerMode(powerMode), .opMode(opMode),
    .modeContinuous(modeContinuous), .modeSingle(modeSingle),
    .clkOutEnable(clkOutEnable), .useExtClock(useExtClock), .modClkTick(modClkTick),
    .writeErr(writeErr), .readErr(readErr), .serialClockCountError(cntErr),
    .serialReset(serialReset));
  acr_host_model acr_host_model_i (.clk(clk), .sclk(sclk), .din(din), .csN(csN),
    .doutRdyN(doutRdyN), .rxDone(rxDone), .rxData(rxData), .rxHold(rxHold));

  // Clock at 100 ns period.
  always #50 clk = ~clk;

  // Random oscillator ticks, external clock toggling every clock; pulses are caught so short ones are not missed.
  always @(posedge clk) begin
    oscTick <= 1'($random(seed));
    extClk <= ~extClk;
    seen <= seen | {serialReset, cntErr, readErr, writeErr};
  end

  task automatic check(input string what, input logic [31:0] sv, input logic [31:0] ev);
    n_compared++;
    if (sv !== ev) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, ev, sv);
    end
  endtask

  // Each finished frame is compared with the oldest note.
  always @(posedge clk) begin
    if (rxDone === 1'b1) check("reply", rxData & mskQ.pop_front(), expQ.pop_front());
  end

  task automatic frame(input logic [7:0] c, input logic u, input int n, input logic [63:0] t,
                       input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    acr_host_model_i.xfer(c, u, n, t);
  endtask

  task automatic wr(input logic [15:0] v);
    frame(8'h01, 1'b1, 16, {48'h0, v}, 32'h0, 32'h0);
  endtask

  task automatic rdCtrl(input logic [15:0] v);
    frame(8'h41, 1'b1, 16, 64'h0, {16'h0, v}, 32'h0000FFFF);
  endtask

  // New result, then a data read; with u clear no command is sent and the read must start on its own.
  task automatic conv(input logic u, input logic app, input logic fr, input logic [63:0] t);
    logic [23:0] d;
    logic [6:0]  s;
    d = 24'($random(seed));
    s = 7'($random(seed));
    @(posedge clk) convData <= d;
    statusLow <= s;
    convValid <= 1'b1;
    @(posedge clk) convValid <= 1'b0;
    for (int i = 0; i < 20 && doutRdyN !== 1'b0; i++) @(posedge clk);
    check("ready", {31'h0, doutRdyN}, 32'h0);
    if (app) frame(8'h42, u, 32, t, {d, 1'b0, s}, 32'hFFFFFF7F);
    else frame(8'h42, u, 24, t, {8'h0, d}, 32'h00FFFFFF);
    check("hold", {31'h0, rxHold}, {31'h0, fr ? (app ? s[0] : d[0]) : 1'b1});
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang is cut after far more than the sequence needs.
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("[ERR] watchdog expected end seen hang");
    end_sim();
  end

  initial begin
    logic [15:0] v;
    logic [1:0]  c;
    logic [31:0] n;    // Modulator ticks counted in a window.
    logic [1:0]  dec;  // Expected continuous and single decode.
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("rst", {23'h0, referenceOutputPin, powerMode, opMode, useExtClock, doutRdyN},
          32'h00000001);
    // Every power and clock code; modes 0 and 1 forced first, random after.
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      v = {7'h00, c[0], c, (i < 2) ? 4'(i) : 4'($random(seed)), c};
      wr(v);
      check("pwr", {30'h0, powerMode}, {30'h0, c[1], c == 2'b01});
      check("mode", {28'h0, opMode}, {28'h0, v[5:2]});
      check("clk", {30'h0, clkOutEnable, useExtClock}, {30'h0, c == 2'b01, c[1]});
      check("ref", {31'h0, referenceOutputPin}, {31'h0, c[0]});
      dec = {v[5:2] == acr_pkg::MODE_CONT, v[5:2] == acr_pkg::MODE_SINGLE};
      check("opdec", {30'h0, modeContinuous, modeSingle}, {30'h0, dec});
      // External edges come every 2 clocks, so 80 clocks hold 40 ticks, or 10 divided.
      n = 32'h00000000;
      repeat (80) @(posedge clk) n += {31'h0, modClkTick};
      if (c[1]) check("tick", n, c[0] ? 32'h0000000A : 32'h00000028);
      rdCtrl(v);
    end
    $display("test config done");
    // Framing on and off, each with append and long ready delay both clear or both set.
    for (int j = 0; j < 4; j++) begin
      v = {3'h0, j[1], 1'b0, j[1], j[0], 9'h000};
      wr(v);
      conv(1'b1, v[10], v[9], 64'h0);
    end
    $display("test data done");
    rdCtrl(v);
    wr(16'h0800);
    conv(1'b1, 1'b0, 1'b0, 64'h0);
    conv(1'b0, 1'b0, 1'b0, 64'h0);
    conv(1'b0, 1'b0, 1'b0, {40'h0, 8'h42, 16'h0});
    rdCtrl(16'h0000);
    frame(8'h40, 1'b1, 8, 64'h0, {24'h0, 1'b1, statusLow}, 32'h000000FF);
    $display("test continuous done");
    wr(16'h0140);
    @(negedge clk) seen = 4'h0;
    frame(8'h00, 1'b0, 64, '1, 32'h0, 32'h0);
    check("sreset", {31'h0, seen[3]}, 32'h1);
    rdCtrl(16'h0000);
    $display("test serial reset done");
    for (int k = 1; k >= 0; k--) begin
      wr(k[0] ? 16'h0200 : 16'h0000);
      @(negedge clk) seen = 4'h0;
      frame(8'h00, 1'b1, 8, 64'h0, 32'h0, 32'h0);
      frame(8'h7F, 1'b1, 8, 64'h0, 32'h0, 32'h0);
      frame(8'h01, 1'b1, 5, 64'h0, 32'h0, 32'h0);
      check("diag", {29'h0, seen[2:0]}, k[0] ? 32'h7 : 32'h0);
    end
    $display("test diagnostics done");
    end_sim();
  end
endmodule
